// ---- src/ssw_pkg.sv ----
// Shared constants for the supply supervisor and watchdog block
package ssw_pkg;

   // Clock and internal timebase
   localparam int CLK_HZ          = 125_000_000;
   localparam int TICK_MS         = 1;
   localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;

   // Reset stretch after supply recovery, in ms
   localparam int STRETCH_MS      = 50;
   localparam int STRETCH_LONG_MS = 200;
   localparam logic [15:0] STRETCH_TICKS =
      16'(STRETCH_MS / TICK_MS);
   localparam logic [15:0] STRETCH_LONG_TICKS =
      16'(STRETCH_LONG_MS / TICK_MS);

   // Watchdog periods on the internal oscillator, in ms
   localparam int WDT_SHORT_MS    = 100;
   localparam int WDT_LONG_MS     = 1600;
   localparam logic [15:0] WDT_SHORT_TICKS = 16'(WDT_SHORT_MS / TICK_MS);
   localparam logic [15:0] WDT_LONG_TICKS  = 16'(WDT_LONG_MS / TICK_MS);

   // Watchdog period on the external timebase
   localparam int WDT_EXT_S       = 100;
   localparam int EXT_EDGE_MS     = 100;
   localparam int WDT_EXT_EDGES   = WDT_EXT_S * 1000 / EXT_EDGE_MS;

   // Register byte offsets
   localparam logic [11:0] CTRL_OFF     = 12'h000;
   localparam logic [11:0] STATUS_OFF   = 12'h004;
   localparam logic [11:0] IRQ_STAT_OFF = 12'h008;
   localparam logic [11:0] IRQ_MASK_OFF = 12'h00c;

   // Field positions
   localparam int CTRL_LONG_BIT   = 0;
   localparam int EV_WDT_BIT      = 0;
   localparam int EV_SUPPLY_BIT   = 1;
   localparam int EV_WARN_BIT     = 2;
   localparam int EV_W            = 3;

   // Reset values
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;

   // Supervisor states
   typedef enum logic [1:0] {
      st_low,
      st_stretch,
      st_run
   } ssw_state_type;

endpackage : ssw_pkg

// ---- src/ssw_sync_edge.sv ----
// Two-stage synchroniser with edge detect on the settled level
`timescale 1ns/1ps
`default_nettype none
module ssw_sync_edge (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Raw input
   input  wire logic din,
   // Synchronised level and any-edge pulse
   output logic      level,
   output logic      any_edge
);

   logic meta_q;
   logic sync_q;
   logic prev_q;

   // Synchroniser chain and delayed copy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edge seen only on the second stage and later
   assign level    = sync_q;
   assign any_edge = sync_q ^ prev_q;

endmodule : ssw_sync_edge
`default_nettype wire

// ---- src/ssw_tick.sv ----
// Prescaler giving one-cycle ticks every CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
module ssw_tick #(
   parameter int CYCLES = 125000
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Tick pulse
   output logic      tick
);

   localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] cnt_q;
   logic         tick_q;

   // Free-running divider
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
         tick_q <= (cnt_q == LAST);
      end
   end

   assign tick = tick_q;

endmodule : ssw_tick
`default_nettype wire

// ---- src/ssw_top.sv ----
// Supply supervisor, reset stretcher, watchdog and chip-select gate
// Behaviour
// - Reset low while supply below threshold
// - Hold reset 50 ms after recovery, option 200
// - Missed period gives a reset pulse
// - Undriven toggle input disables the watchdog
// - Select low: period from external timebase
// - Select high: internal 100 ms or 1.6 s
// - Backup mode holds memory select high
// - Backup flag low while main above battery
// - Warning low while sense below reference
// - Active-high reset is inverse of reset
// - Expired flag low until toggle, high undervoltage
// - Memory select passes when supply valid
// - Pulse repeats each period until toggled
// - Backup mode ignores toggle and timebase
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ssw_top #(
   parameter int TICK_CYCLES   = ssw_pkg::TICK_CYCLES,
   parameter int WDT_EXT_EDGES = ssw_pkg::WDT_EXT_EDGES
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Supply indications
   input  wire logic        supply_ok,
   input  wire logic        batt_mode,
   input  wire logic        supply_below_ref,
   // Watchdog and timebase pins
   input  wire logic        watchdog_toggle_in,
   input  wire logic        watchdog_toggle_driven,
   input  wire logic        timebase_select,
   input  wire logic        timebase_input,
   // Memory select gate
   input  wire logic        mem_select_in,
   output logic             mem_select_out,
   // Status and reset outputs
   output logic             proc_reset_n,
   output logic             proc_reset,
   output logic             watchdog_expired_n,
   output logic             backup_source_flag,
   output logic             supply_warn_n,
   output logic             irq
);

   localparam logic [15:0] EXT_LIMIT = 16'(WDT_EXT_EDGES);

   // State and registers
   ssw_pkg::ssw_state_type state_q;
   ssw_pkg::ssw_state_type state_d;
   logic [15:0]            str_cnt_q;
   logic [15:0]            wdt_cnt_q;
   logic                   strap_q;
   logic                   ctrl_long_q;
   logic [ssw_pkg::EV_W-1:0] irq_stat_q;
   logic [ssw_pkg::EV_W-1:0] irq_mask_q;
   logic                   bad_prev_q;
   logic                   warn_prev_q;
   logic                   proc_reset_n_q;
   logic                   proc_reset_q;
   logic                   watchdog_expired_n_q;
   logic                   mem_select_out_q;
   logic                   backup_source_flag_q;
   logic                   supply_warn_n_q;
   logic                   irq_q;
   logic [31:0]            prdata_q;
   logic                   pready_q;
   logic                   pslverr_q;

   // Submodule outputs
   logic ms_tick;
   logic tog_level;
   logic tog_edge;
   logic tb_level;
   logic tb_edge;

   // Millisecond tick from the internal oscillator
   ssw_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk   (pclk),
      .rst_n (presetn),
      .tick  (ms_tick)
   );

   // Toggle input synchroniser
   ssw_sync_edge u_tog (
      .clk      (pclk),
      .rst_n    (presetn),
      .din      (watchdog_toggle_in),
      .level    (tog_level),
      .any_edge (tog_edge)
   );

   // External timebase synchroniser
   ssw_sync_edge u_tb (
      .clk      (pclk),
      .rst_n    (presetn),
      .din      (timebase_input),
      .level    (tb_level),
      .any_edge (tb_edge)
   );

   // Supply condition decode
   wire supply_bad = !supply_ok || batt_mode;

   // Stretch length and end
   wire [15:0] str_limit = ctrl_long_q ? ssw_pkg::STRETCH_LONG_TICKS
                                       : ssw_pkg::STRETCH_TICKS;
   wire str_done = ms_tick && (str_cnt_q >= str_limit - 16'h0001);

   // Watchdog enable, tick source and period
   wire wdt_active = watchdog_toggle_driven && !supply_bad &&
                     (state_q == ssw_pkg::st_run);
   wire wdt_tick = timebase_select ? ms_tick : tb_edge;
   wire [15:0] int_limit = strap_q ? ssw_pkg::WDT_LONG_TICKS
                                   : ssw_pkg::WDT_SHORT_TICKS;
   wire [15:0] wdt_limit = timebase_select ? int_limit
                                           : EXT_LIMIT;
   wire wdt_timeout = wdt_active && !tog_edge && wdt_tick &&
                      (wdt_cnt_q >= wdt_limit - 16'h0001);

   // Supervisor next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ssw_pkg::st_low: begin
            if (!supply_bad) begin
               state_d = ssw_pkg::st_stretch;
            end
         end
         ssw_pkg::st_stretch: begin
            if (supply_bad) begin
               state_d = ssw_pkg::st_low;
            end else if (str_done) begin
               state_d = ssw_pkg::st_run;
            end
         end
         ssw_pkg::st_run: begin
            if (supply_bad) begin
               state_d = ssw_pkg::st_low;
            end else if (wdt_timeout) begin
               state_d = ssw_pkg::st_stretch;
            end
         end
         default: begin
            state_d = ssw_pkg::st_low;
         end
      endcase
   end

   // State and stretch counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q   <= ssw_pkg::st_low;
         str_cnt_q <= 16'h0000;
      end else begin
         state_q   <= state_d;
         if (state_q != ssw_pkg::st_stretch || state_d != state_q) begin
            str_cnt_q <= 16'h0000;
         end else if (ms_tick) begin
            str_cnt_q <= str_cnt_q + 16'h0001;
         end
      end
   end

   // Watchdog period counter, restarted by either toggle edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_cnt_q <= 16'h0000;
      end else if (!wdt_active || tog_edge || wdt_timeout) begin
         wdt_cnt_q <= 16'h0000;
      end else if (wdt_tick) begin
         wdt_cnt_q <= wdt_cnt_q + 16'h0001;
      end
   end

   // Strap on the timebase pin, frozen in backup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_q <= 1'b0;
      end else if (timebase_select && !batt_mode) begin
         strap_q <= tb_level;
      end
   end

   // Pin outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         proc_reset_n_q       <= 1'b0;
         proc_reset_q         <= 1'b1;
         watchdog_expired_n_q <= 1'b1;
         mem_select_out_q     <= 1'b1;
         backup_source_flag_q <= 1'b1;
         supply_warn_n_q      <= 1'b1;
      end else begin
         proc_reset_n_q   <= (state_d == ssw_pkg::st_run);
         proc_reset_q     <= (state_d != ssw_pkg::st_run);
         mem_select_out_q <= supply_bad | mem_select_in;
         backup_source_flag_q <= batt_mode;
         supply_warn_n_q  <= !(supply_below_ref || batt_mode);
         if (supply_bad) begin
            watchdog_expired_n_q <= 1'b1;
         end else if (wdt_timeout) begin
            watchdog_expired_n_q <= 1'b0;
         end else if (tog_edge) begin
            watchdog_expired_n_q <= 1'b1;
         end
      end
   end

   // APB decode
   wire apb_acc   = psel && penable && pready_q;
   wire apb_wr    = apb_acc && pwrite;
   wire sel_ctrl  = (paddr == ssw_pkg::CTRL_OFF);
   wire sel_stat  = (paddr == ssw_pkg::STATUS_OFF);
   wire sel_istat = (paddr == ssw_pkg::IRQ_STAT_OFF);
   wire sel_imask = (paddr == ssw_pkg::IRQ_MASK_OFF);
   wire mapped    = sel_ctrl || sel_stat || sel_istat || sel_imask;

   // Interrupt events and write-one-to-clear
   wire [ssw_pkg::EV_W-1:0] ev;
   assign ev[ssw_pkg::EV_WDT_BIT]    = wdt_timeout;
   assign ev[ssw_pkg::EV_SUPPLY_BIT] = supply_bad && !bad_prev_q;
   assign ev[ssw_pkg::EV_WARN_BIT]   = supply_below_ref && !warn_prev_q;
   wire [ssw_pkg::EV_W-1:0] clr = (apb_wr && sel_istat) ?
                                  pwdata[ssw_pkg::EV_W-1:0] : '0;
   wire [ssw_pkg::EV_W-1:0] irq_stat_d = (irq_stat_q & ~clr) | ev;

   // Live status word
   wire [31:0] status_word = {27'h0, supply_ok, batt_mode,
                              supply_below_ref, !watchdog_expired_n_q,
                              !proc_reset_n_q};

   // Read data select
   wire [31:0] rd_mux =
      sel_ctrl  ? {31'h0, ctrl_long_q} :
      sel_stat  ? status_word :
      sel_istat ? {29'h0, irq_stat_q} :
      sel_imask ? {29'h0, irq_mask_q} : 32'h0000_0000;

   // Control, interrupt registers and edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_long_q <= ssw_pkg::CTRL_RST[ssw_pkg::CTRL_LONG_BIT];
         irq_stat_q  <= '0;
         irq_mask_q  <= ssw_pkg::IRQ_MASK_RST;
         bad_prev_q  <= 1'b1;
         warn_prev_q <= 1'b0;
         irq_q       <= 1'b0;
      end else begin
         if (apb_wr && sel_ctrl) begin
            ctrl_long_q <= pwdata[ssw_pkg::CTRL_LONG_BIT];
         end
         if (apb_wr && sel_imask) begin
            irq_mask_q <= pwdata[ssw_pkg::EV_W-1:0];
         end
         irq_stat_q  <= irq_stat_d;
         bad_prev_q  <= supply_bad;
         warn_prev_q <= supply_below_ref;
         irq_q       <= |(irq_stat_d & irq_mask_q);
      end
   end

   // APB answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !mapped;
         prdata_q  <= (psel && penable && !pready_q && !pwrite) ?
                      rd_mux : 32'h0000_0000;
      end
   end

   // Output ports
   assign prdata             = prdata_q;
   assign pready             = pready_q;
   assign pslverr            = pslverr_q;
   assign proc_reset_n       = proc_reset_n_q;
   assign proc_reset         = proc_reset_q;
   assign watchdog_expired_n = watchdog_expired_n_q;
   assign mem_select_out     = mem_select_out_q;
   assign backup_source_flag = backup_source_flag_q;
   assign supply_warn_n      = supply_warn_n_q;
   assign irq                = irq_q;

   // Checks on the outputs, the watchdog timeout and the watchdog period counter
   rst_low_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      supply_bad |=> !proc_reset_n_q)
      else $error("reset not low");
   rst_inv_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      proc_reset_q == !proc_reset_n_q)
      else $error("reset not inverse");
   str_hold_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (state_q == ssw_pkg::st_low && !supply_bad)
      |=> !proc_reset_n_q[*8])
      else $error("stretch too short");
   wdt_pulse_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      wdt_timeout |=> (!proc_reset_n_q && !watchdog_expired_n_q))
      else $error("no watchdog reset");
   wdt_off_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (!watchdog_toggle_driven || batt_mode) |-> !wdt_timeout)
      else $error("timeout while disabled");
   cs_force_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      supply_bad |=> mem_select_out_q)
      else $error("select not forced");
   cs_pass_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      !supply_bad |=> (mem_select_out_q == $past(mem_select_in)))
      else $error("select not passed");
   batt_flag_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(presetn) |-> (backup_source_flag_q == $past(batt_mode)))
      else $error("backup flag wrong");
   warn_low_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      supply_below_ref |=> !supply_warn_n_q)
      else $error("warning missed");
   wdo_hold_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (!watchdog_expired_n_q && !tog_edge && !supply_bad)
      |=> !watchdog_expired_n_q)
      else $error("expired flag dropped");
   wdo_bad_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      supply_bad |=> watchdog_expired_n_q)
      else $error("expired flag not high");
   tog_restart_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      tog_edge |=> (wdt_cnt_q == 16'h0000))
      else $error("no restart");

endmodule : ssw_top
`default_nettype wire

// ---- sim/ssw_host_model.sv ----
// Host processor model: watchdog servicing and external timebase
`timescale 1ns/1ps
`default_nettype none
module ssw_host_model #(
   parameter int HALF     = 200,
   parameter int EXT_HALF = 40
) (
   // Clock
   input  wire logic pclk,
   // Scenario controls
   input  wire logic service,
   input  wire logic float_pin,
   input  wire logic ext_run,
   input  wire logic strap,
   // Pins toward the supervisor
   output logic      watchdog_toggle_in,
   output logic      watchdog_toggle_driven,
   output logic      timebase_input
);
   logic drv_q = 1'b0;
   logic osc_q = 1'b0;
   int   cnt   = 0;
   int   ecnt  = 0;
   // Software loop toggles the pin every HALF cycles while servicing
   always @(posedge pclk) begin
      cnt <= (cnt >= HALF - 1) ? 0 : cnt + 1;
      ecnt <= (ecnt >= EXT_HALF - 1) ? 0 : ecnt + 1;
      if (service && cnt == HALF - 1) drv_q <= ~drv_q;
      if (ext_run && ecnt == EXT_HALF - 1) osc_q <= ~osc_q;
   end
   // Released pin shows the inverse of its last driven level
   assign watchdog_toggle_driven = ~float_pin;
   assign watchdog_toggle_in     = float_pin ? ~drv_q : drv_q;
   // External edges, or a strap level on the timebase pin
   assign timebase_input = ext_run ? osc_q : strap;
endmodule : ssw_host_model
`default_nettype wire

// ---- sim/supply_supervisor_watchdog_test.sv ----
// Self-checking bench for the supply supervisor and watchdog
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_test;
   localparam int TK  = 10;
   localparam int STR = int'(ssw_pkg::STRETCH_TICKS) * TK;
   localparam int STL = int'(ssw_pkg::STRETCH_LONG_TICKS) * TK;
   localparam int WS  = int'(ssw_pkg::WDT_SHORT_TICKS) * TK;
   localparam int WL  = int'(ssw_pkg::WDT_LONG_TICKS) * TK;
   localparam int WE  = 8 * 40;
   // Bus and pins
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        supply_ok, batt_mode, below, tg, tg_drv, tsel, tin;
   logic        cs_in, cs_out, rst_n, rst, exp_n, bflag, warn_n, irq;
   logic        service, flt, ext_run, strap, er;
   logic [16:0] rnd;
   logic [2:0]  h1;
   logic [31:0] ef;
   int          n, errors, checks;

   // Short ticks keep every duration small
   ssw_top #(.TICK_CYCLES(TK), .WDT_EXT_EDGES(8)) ssw_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
      .batt_mode(batt_mode), .supply_below_ref(below),
      .watchdog_toggle_in(tg), .watchdog_toggle_driven(tg_drv),
      .timebase_select(tsel), .timebase_input(tin),
      .mem_select_in(cs_in), .mem_select_out(cs_out),
      .proc_reset_n(rst_n), .proc_reset(rst), .watchdog_expired_n(exp_n),
      .backup_source_flag(bflag), .supply_warn_n(warn_n), .irq(irq));
   ssw_host_model ssw_host_model_i (
      .pclk(pclk), .service(service), .float_pin(flt), .ext_run(ext_run),
      .strap(strap), .watchdog_toggle_in(tg),
      .watchdog_toggle_driven(tg_drv), .timebase_input(tin));

   // Comparison and verdict
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : check
   task results;
      if (errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   // Expected values
   function logic [31:0] near(input int v, input int e, input int t);
      return (v >= e - t && v <= e + t) ? 32'(e) : 32'(v);
   endfunction : near
   function logic [31:0] exp_flags(input logic [2:0] v);
      return {29'h0, v[2] | v[0], v[2], ~(v[1] | v[2])};
   endfunction : exp_flags
   function logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : lfsr
   // One APB transfer, released right after pready is seen
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Wait for the reset output to reach a level, counting cycles
   task till(input logic lvl, input int lim);
      n = 0;
      while (rst_n !== lvl && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask : till
   // Stop servicing just after a toggle
   task stop_svc;
      @(tg);
      @(posedge pclk);
      service <= 1'b0;
   endtask : stop_svc

   // Clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Hang guard
   initial begin
      repeat (60000) @(posedge pclk);
      errors++;
      results;
   end
   // Main sequence
   initial begin
      errors = 0;
      checks = 0;
      rnd = 17'd73867;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {supply_ok, batt_mode, below, tsel, cs_in} = 5'b10011;
      {service, flt, ext_run, strap} = 4'b1000;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check(32'(rst_n), 32'h0);
      till(1'b1, 3000);
      check(near(n, STR, 15), 32'(STR));
      // Register reset values, refusals and status
      apb(1'b0, ssw_pkg::CTRL_OFF, 32'h0);
      check(rd, ssw_pkg::CTRL_RST);
      apb(1'b0, ssw_pkg::IRQ_MASK_OFF, 32'h0);
      check(rd, 32'(ssw_pkg::IRQ_MASK_RST));
      apb(1'b0, 12'h010, 32'h0);
      check({rd[30:0], er}, 32'h1);
      apb(1'b1, ssw_pkg::STATUS_OFF, 32'hffff_ffff);
      check(32'(er), 32'h0);
      apb(1'b0, ssw_pkg::STATUS_OFF, 32'h0);
      check(rd & 32'h1f, 32'h10);
      apb(1'b1, ssw_pkg::IRQ_MASK_OFF, 32'h1);
      // Supply loss with the long stretch selected
      apb(1'b1, ssw_pkg::CTRL_OFF, 32'h1);
      cs_in <= 1'b0;
      supply_ok <= 1'b0;
      repeat (50) @(posedge pclk);
      check(32'({rst_n, rst, cs_out}), 32'h3);
      supply_ok <= 1'b1;
      @(posedge pclk);
      till(1'b1, 3000);
      check(near(n, STL, 15), 32'(STL));
      apb(1'b1, ssw_pkg::CTRL_OFF, 32'h0);
      // Random backup, warning and memory select levels
      h1 = 3'b000;
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         {batt_mode, below, cs_in} <= rnd[2:0];
         @(posedge pclk);
         ef = exp_flags(h1);
         check(32'(cs_out), 32'(ef[2]));
         check(32'(bflag), 32'(ef[1]));
         check(32'(warn_n), 32'(ef[0]));
         check(32'(rst ^ rst_n), 32'h1);
         h1 = rnd[2:0];
      end
      {batt_mode, below, cs_in} <= 3'b001;
      @(posedge pclk);
      till(1'b1, 3000);
      // Internal short period: serviced, then starved
      till(1'b0, 1500);
      check(32'(n), 32'd1500);
      stop_svc;
      till(1'b0, 2000);
      check(near(n, WS, 25), 32'(WS));
      repeat (3) @(posedge pclk);
      check(32'({exp_n, irq}), 32'h1);
      apb(1'b0, ssw_pkg::IRQ_STAT_OFF, 32'h0);
      check(rd & 32'h1, 32'h1);
      till(1'b1, 2000);
      check(near(n, STR, 25), 32'(STR));
      till(1'b0, 2000);
      check(near(n, WS, 25), 32'(WS));
      check(32'(exp_n), 32'h0);
      supply_ok <= 1'b0;
      repeat (4) @(posedge pclk);
      check(32'(exp_n), 32'h1);
      service <= 1'b1;
      supply_ok <= 1'b1;
      // Mask, then clear the sticky events
      apb(1'b1, ssw_pkg::IRQ_MASK_OFF, 32'h0);
      @(posedge pclk);
      check(32'(irq), 32'h0);
      apb(1'b1, ssw_pkg::IRQ_STAT_OFF, 32'h7);
      apb(1'b0, ssw_pkg::IRQ_STAT_OFF, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, ssw_pkg::IRQ_MASK_OFF, 32'h1);
      till(1'b1, 3000);
      // Floating toggle pin keeps the watchdog quiet
      flt <= 1'b1;
      service <= 1'b0;
      till(1'b0, 3000);
      check(32'({rst_n, exp_n}), 32'h3);
      flt <= 1'b0;
      service <= 1'b1;
      // Internal long period by strap
      strap <= 1'b1;
      repeat (20) @(posedge pclk);
      stop_svc;
      till(1'b0, 17000);
      check(near(n, WL, 25), 32'(WL));
      service <= 1'b1;
      strap <= 1'b0;
      till(1'b1, 3000);
      // External timebase period
      tsel <= 1'b0;
      ext_run <= 1'b1;
      repeat (20) @(posedge pclk);
      stop_svc;
      till(1'b0, 2000);
      check(near(n, WE, 50), 32'(WE));
      results;
   end
endmodule : supply_supervisor_watchdog_test
`default_nettype wire
